// ===== hw/edls_regs.vh
// Overview of operation
// - List runs only while enable bit is set.
// - List starts each frame at scan line eight.
// - Vertical sync reloads fetch pointer from base.
// - Two control bytes, optional blocks, parameters persist.
// - Repeat byte adds extra mode line displays.
// - Overlay address three bytes, stride two bytes.
// - Control bit seven loads text scroll values.
// - Font base byte gives address bits 18-11.
// - Attribute address and stride, stride multiple four.
// - Attribute scroll and cell size, minus one.
// - Misc palettes, width, then overlay priority mask.
// - Second byte bit seven ends list.
// - Frame start resets scroll, width, priority.
// - Frame start resets attribute map and palettes.
// - Overlay and attribute addresses persist across frames.
// - Entries fetched from 512K local memory.
// - Timing from host; no interrupts raised.
// - Host color chip writes captured, reads not.
// - Overlay mode from text, graphics, lores, hires.
`ifndef EDLS_REGS_VH
`define EDLS_REGS_VH
`define EDLS_START_LINE     9'h008
`define EDLS_C1_TEXT        0
`define EDLS_C1_GFX         1
`define EDLS_C1_OVOFF       2
`define EDLS_C1_MAPON       3
`define EDLS_C1_MAPOFF      4
`define EDLS_C1_RPT         5
`define EDLS_C1_OVADR       6
`define EDLS_C1_OVSCR       7
`define EDLS_C2_FONT        0
`define EDLS_C2_ATADR       1
`define EDLS_C2_ATLAY       2
`define EDLS_C2_MISC        3
`define EDLS_C2_HIRES       4
`define EDLS_C2_LORES       5
`define EDLS_C2_END         7
`define EDLS_WIDTH_NORMAL   2'h1
`define EDLS_PRIO_DEF       8'hff
`define EDLS_CELL_DEF       5'h07
`define EDLS_PAL_PF_DEF     2'h0
`define EDLS_PAL_OV_DEF     2'h1
`define EDLS_LAST_ONE       3'h0
`define EDLS_LAST_TWO       3'h1
`define EDLS_LAST_FOUR      3'h3
`define EDLS_LAST_FIVE      3'h4
`define EDLS_PF_PAL         7:6
`define EDLS_OV_PAL         5:4
`define EDLS_WIDTH          1:0
`endif

// ===== hw/edls_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "edls_regs.vh"
module edls_sequencer (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        reset_n,
    // Control and frame timing from the host display chip.
    input  wire        list_enable,
    input  wire [18:0] list_base_address,
    input  wire        vsync_start,
    input  wire        line_start,
    input  wire [8:0]  scan_line,
    // Host writes aimed at the color chip.
    input  wire        host_wr,
    input  wire [4:0]  host_addr,
    input  wire [7:0]  host_wdata,
    // Local memory read port.
    output reg         mem_req,
    output reg  [18:0] mem_addr,
    input  wire        mem_ack,
    input  wire [7:0]  mem_rdata,
    // Decoded parameters.
    output reg         line_valid,
    output reg         ov_text,
    output reg         ov_gfx,
    output reg         ov_lores,
    output reg         ov_hires,
    output reg         overlay_off,
    output reg  [18:0] ov_addr,
    output reg  [11:0] ov_stride,
    output reg  [7:0]  ov_hscroll,
    output reg  [7:0]  ov_vscroll,
    output reg  [7:0]  font_base,
    output reg         attr_map_on,
    output reg  [18:0] at_addr,
    output reg  [11:0] at_stride,
    output reg  [4:0]  at_hscroll,
    output reg  [4:0]  at_vscroll,
    output reg  [4:0]  at_cell_w,
    output reg  [4:0]  at_cell_h,
    output reg  [1:0]  pal_pf,
    output reg  [1:0]  pal_ov,
    output reg  [1:0]  ov_width,
    output reg  [7:0]  ov_prio,
    // Captured color chip writes; reads are left to that chip.
    output reg         shadow_we,
    output reg  [4:0]  shadow_addr,
    output reg  [7:0]  shadow_data
);
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_WAIT = 5'h02;
    localparam [4:0] S_FTCH = 5'h04;
    localparam [4:0] S_SHOW = 5'h08;
    localparam [4:0] S_DONE = 5'h10;
    // Block numbers in fetch order; misc, fetched last, reuses zero.
    localparam [2:0] B_C1 = 3'h0;
    localparam [2:0] B_C2 = 3'h1;
    localparam [2:0] B_RPT = 3'h2;
    localparam [2:0] B_OVA = 3'h3;
    localparam [2:0] B_OVS = 3'h4;
    localparam [2:0] B_FNT = 3'h5;
    localparam [2:0] B_ATA = 3'h6;
    localparam [2:0] B_ATL = 3'h7;
    localparam [2:0] B_MSC = 3'h0;

    reg  [4:0]  state_reg;
    reg  [2:0]  blk_reg;
    reg         msc_reg;
    reg  [2:0]  idx_reg;
    reg  [7:0]  c1_reg;
    reg  [7:0]  c2_reg;
    reg  [7:0]  rpt_reg;
    reg  [18:0] ptr_reg;
    reg         en_s1_reg;
    reg         en_s2_reg;

    // Block length in bytes, minus one.
    function [2:0] blk_last;
        input [2:0] b;
        input       m;
        begin
            if (m)
                blk_last = `EDLS_LAST_TWO;
            else begin
                case (b)
                    B_C1: blk_last = `EDLS_LAST_ONE;
                    B_C2: blk_last = `EDLS_LAST_ONE;
                    B_RPT: blk_last = `EDLS_LAST_ONE;
                    B_OVA: blk_last = `EDLS_LAST_FIVE;
                    B_OVS: blk_last = `EDLS_LAST_TWO;
                    B_FNT: blk_last = `EDLS_LAST_ONE;
                    B_ATA: blk_last = `EDLS_LAST_FIVE;
                    B_ATL: blk_last = `EDLS_LAST_FOUR;
                    default: blk_last = `EDLS_LAST_ONE;
                endcase
            end
        end
    endfunction

    // Whether a block is enabled by the control bytes.
    function blk_on;
        input [2:0] b;
        input       m;
        input [7:0] a;
        input [7:0] c;
        begin
            if (m)
                blk_on = c[`EDLS_C2_MISC];
            else begin
                case (b)
                    B_C1: blk_on = 1'b1;
                    B_C2: blk_on = 1'b1;
                    B_RPT: blk_on = a[`EDLS_C1_RPT];
                    B_OVA: blk_on = a[`EDLS_C1_OVADR];
                    B_OVS: blk_on = a[`EDLS_C1_OVSCR];
                    B_FNT: blk_on = c[`EDLS_C2_FONT];
                    B_ATA: blk_on = c[`EDLS_C2_ATADR];
                    B_ATL: blk_on = c[`EDLS_C2_ATLAY];
                    default: blk_on = 1'b1;
                endcase
            end
        end
    endfunction

    wire last_byte = (idx_reg == blk_last(blk_reg, msc_reg));

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
        end else begin
            en_s1_reg <= list_enable;
            en_s2_reg <= en_s1_reg;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shadow_we <= 1'b0;
            shadow_addr <= 5'h00;
            shadow_data <= 8'h00;
        end else begin
            shadow_we <= host_wr;
            shadow_addr <= host_addr;
            shadow_data <= host_wdata;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            blk_reg <= B_C1;
            msc_reg <= 1'b0;
            idx_reg <= 3'h0;
            c1_reg <= 8'h00;
            c2_reg <= 8'h00;
            rpt_reg <= 8'h00;
            ptr_reg <= 19'h00000;
            mem_req <= 1'b0;
            mem_addr <= 19'h00000;
            line_valid <= 1'b0;
            ov_text <= 1'b0;
            ov_gfx <= 1'b0;
            ov_lores <= 1'b0;
            ov_hires <= 1'b0;
            overlay_off <= 1'b0;
            ov_addr <= 19'h00000;
            ov_stride <= 12'h000;
            ov_hscroll <= 8'h00;
            ov_vscroll <= 8'h00;
            font_base <= 8'h00;
            attr_map_on <= 1'b0;
            at_addr <= 19'h00000;
            at_stride <= 12'h000;
            at_hscroll <= 5'h00;
            at_vscroll <= 5'h00;
            at_cell_w <= `EDLS_CELL_DEF;
            at_cell_h <= `EDLS_CELL_DEF;
            pal_pf <= `EDLS_PAL_PF_DEF;
            pal_ov <= `EDLS_PAL_OV_DEF;
            ov_width <= `EDLS_WIDTH_NORMAL;
            ov_prio <= `EDLS_PRIO_DEF;
        end else if (vsync_start) begin
            // Frame defaults; addresses are kept.
            ptr_reg <= list_base_address;
            state_reg <= en_s2_reg ? S_WAIT : S_IDLE;
            mem_req <= 1'b0;
            line_valid <= 1'b0;
            ov_hscroll <= 8'h00;
            ov_vscroll <= 8'h00;
            ov_width <= `EDLS_WIDTH_NORMAL;
            ov_prio <= `EDLS_PRIO_DEF;
            attr_map_on <= 1'b0;
            at_hscroll <= 5'h00;
            at_vscroll <= 5'h00;
            at_cell_w <= `EDLS_CELL_DEF;
            at_cell_h <= `EDLS_CELL_DEF;
            pal_pf <= `EDLS_PAL_PF_DEF;
            pal_ov <= `EDLS_PAL_OV_DEF;
        end else if (!en_s2_reg) begin
            state_reg <= S_IDLE;
            mem_req <= 1'b0;
            line_valid <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    state_reg <= S_IDLE;
                end
                S_WAIT: begin
                    if (line_start && scan_line == `EDLS_START_LINE) begin
                        state_reg <= S_FTCH;
                        blk_reg <= B_C1;
                        msc_reg <= 1'b0;
                        idx_reg <= 3'h0;
                        rpt_reg <= 8'h00;
                        mem_req <= 1'b1;
                        mem_addr <= ptr_reg;
                    end
                end
                S_FTCH: begin
                    if (mem_req && mem_ack) begin
                        mem_req <= 1'b0;
                        ptr_reg <= ptr_reg + 19'h00001;
                        if (!msc_reg) begin
                            case (blk_reg)
                                B_C1: c1_reg <= mem_rdata;
                                B_C2: c2_reg <= mem_rdata;
                                B_RPT: rpt_reg <= mem_rdata;
                                B_OVA: begin
                                    case (idx_reg)
                                        3'h0: ov_addr[7:0] <= mem_rdata;
                                        3'h1: ov_addr[15:8] <= mem_rdata;
                                        3'h2: ov_addr[18:16] <= mem_rdata[2:0];
                                        3'h3: ov_stride[7:0] <= mem_rdata;
                                        default: ov_stride[11:8] <= mem_rdata[3:0];
                                    endcase
                                end
                                B_OVS: begin
                                    if (idx_reg == 3'h0)
                                        ov_hscroll <= mem_rdata;
                                    else
                                        ov_vscroll <= mem_rdata;
                                end
                                B_FNT: font_base <= mem_rdata;
                                B_ATA: begin
                                    case (idx_reg)
                                        3'h0: at_addr[7:0] <= mem_rdata;
                                        3'h1: at_addr[15:8] <= mem_rdata;
                                        3'h2: at_addr[18:16] <= mem_rdata[2:0];
                                        3'h3: at_stride[7:0] <= {mem_rdata[7:2], 2'h0};
                                        default: at_stride[11:8] <= mem_rdata[3:0];
                                    endcase
                                end
                                default: begin
                                    case (idx_reg)
                                        3'h0: at_hscroll <= mem_rdata[4:0];
                                        3'h1: at_vscroll <= mem_rdata[4:0];
                                        3'h2: at_cell_w <= mem_rdata[4:0];
                                        default: at_cell_h <= mem_rdata[4:0];
                                    endcase
                                end
                            endcase
                        end else begin
                            // Palettes and width, then the priority mask.
                            case (idx_reg)
                                3'h0: begin
                                    pal_pf <= mem_rdata[`EDLS_PF_PAL];
                                    pal_ov <= mem_rdata[`EDLS_OV_PAL];
                                    ov_width <= mem_rdata[`EDLS_WIDTH];
                                end
                                default: ov_prio <= mem_rdata;
                            endcase
                        end
                        if (!last_byte)
                            idx_reg <= idx_reg + 3'h1;
                        else begin
                            idx_reg <= 3'h0;
                            // The misc block follows the layout block.
                            if (msc_reg) begin
                                msc_reg <= 1'b0;
                                state_reg <= S_SHOW;
                            end else if (blk_reg == B_ATL) begin
                                msc_reg <= 1'b1;
                                blk_reg <= B_MSC;
                            end else
                                blk_reg <= blk_reg + 3'h1;
                        end
                    end else if (!mem_req) begin
                        // Skip disabled blocks without a fetch.
                        // Misc shares block number zero with the first byte.
                        if (blk_on(blk_reg, msc_reg, c1_reg, c2_reg)) begin
                            mem_req <= 1'b1;
                            mem_addr <= ptr_reg;
                        end else if (blk_reg == B_ATL) begin
                            msc_reg <= 1'b1;
                            blk_reg <= B_MSC;
                        end else if (msc_reg) begin
                            msc_reg <= 1'b0;
                            state_reg <= S_SHOW;
                        end else
                            blk_reg <= blk_reg + 3'h1;
                    end
                end
                S_SHOW: begin
                    if (!line_valid) begin
                        line_valid <= 1'b1;
                        ov_text <= c1_reg[`EDLS_C1_TEXT];
                        ov_gfx <= c1_reg[`EDLS_C1_GFX];
                        ov_lores <= c2_reg[`EDLS_C2_LORES];
                        ov_hires <= c2_reg[`EDLS_C2_HIRES];
                        overlay_off <= c1_reg[`EDLS_C1_OVOFF];
                        if (c1_reg[`EDLS_C1_MAPON])
                            attr_map_on <= 1'b1;
                        else if (c1_reg[`EDLS_C1_MAPOFF])
                            attr_map_on <= 1'b0;
                    end else if (line_start) begin
                        if (rpt_reg != 8'h00)
                            rpt_reg <= rpt_reg - 8'h01;
                        else begin
                            line_valid <= 1'b0;
                            if (c2_reg[`EDLS_C2_END])
                                state_reg <= S_DONE;
                            else begin
                                state_reg <= S_FTCH;
                                blk_reg <= B_C1;
                            end
                        end
                    end
                end
                S_DONE: begin
                    state_reg <= S_DONE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
    // No interrupt outputs exist; timing follows host strobes.
endmodule // edls_sequencer
`default_nettype wire

// ===== dv/edls_sequencer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module edls_sequencer_chk (
    // Clock, reset and control.
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        list_enable,
    input wire logic        vsync_start,
    input wire logic        host_wr,
    input wire logic [4:0]  host_addr,
    input wire logic [7:0]  host_wdata,
    // Memory port.
    input wire logic        mem_req,
    input wire logic        mem_ack,
    input wire logic [18:0] mem_addr,
    // Decoded parameters.
    input wire logic        line_valid,
    input wire logic        attr_map_on,
    input wire logic [18:0] ov_addr,
    input wire logic [18:0] at_addr,
    input wire logic [11:0] at_stride,
    input wire logic [4:0]  at_cell_w,
    input wire logic [4:0]  at_cell_h,
    input wire logic [1:0]  pal_pf,
    input wire logic [1:0]  pal_ov,
    input wire logic [1:0]  ov_width,
    input wire logic [7:0]  ov_prio,
    // Shadowed host writes.
    input wire logic        shadow_we,
    input wire logic [4:0]  shadow_addr,
    input wire logic [7:0]  shadow_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_no_fetch_off: assert property ((!list_enable)[*6] |-> !mem_req)
        else $error("fetch while list disabled");
    a_req_holds: assert property (mem_req && !mem_ack && !vsync_start
        && list_enable && $past(list_enable, 4)
        |=> mem_req && $stable(mem_addr))
        else $error("request dropped or moved before answer");
    a_line_no_fetch: assert property (line_valid |-> !mem_req)
        else $error("fetch while mode line shown");
    a_ov_defaults: assert property (vsync_start && list_enable |=>
        ov_width == 2'h1 && ov_prio == 8'hff)
        else $error("overlay defaults not applied");
    a_map_defaults: assert property (vsync_start && list_enable |=>
        !attr_map_on && at_cell_w == 5'h07 && at_cell_h == 5'h07
        && pal_pf == 2'h0 && pal_ov == 2'h1)
        else $error("attribute map defaults not applied");
    a_addr_kept: assert property (vsync_start |=>
        $stable(ov_addr) && $stable(at_addr))
        else $error("addresses changed at frame start");
    a_stride_mult: assert property (at_stride[1:0] == 2'h0)
        else $error("attribute stride not a multiple of four");
    a_shadow_copy: assert property (host_wr |=> shadow_we
        && shadow_addr == $past(host_addr)
        && shadow_data == $past(host_wdata))
        else $error("host write not shadowed");
endmodule // edls_sequencer_chk

bind edls_sequencer edls_sequencer_chk u_edls_sequencer_chk (
    .sys_clk, .reset_n, .list_enable, .vsync_start, .host_wr, .host_addr,
    .host_wdata, .mem_req, .mem_ack, .mem_addr, .line_valid, .attr_map_on,
    .ov_addr, .at_addr, .at_stride, .at_cell_w, .at_cell_h, .pal_pf,
    .pal_ov, .ov_width, .ov_prio, .shadow_we, .shadow_addr, .shadow_data
);
`default_nettype wire

// ===== dv/edls_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module edls_mem_model (
    // Clock.
    input wire logic        sys_clk,
    // Local memory read port.
    input wire logic        mem_req,
    input wire logic [18:0] mem_addr,
    output logic            mem_ack,
    output logic [7:0]      mem_rdata
);
    logic [7:0] mem [0:1023];
    int         lat;
    int         cnt;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        lat = 0;
        cnt = 0;
    end
    // Answers after lat waiting cycles; idle data flips every cycle.
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (cnt >= lat) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[9:0]];
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // edls_mem_model
`default_nettype wire

// ===== dv/edls_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module edls_sequencer_test;
    logic        sys_clk, reset_n, list_enable, vsync_start, line_start;
    logic        host_wr;
    logic [18:0] list_base_address;
    logic [8:0]  scan_line;
    logic [4:0]  host_addr;
    logic [7:0]  host_wdata;
    wire         mem_req, mem_ack, line_valid, ov_text, ov_gfx, ov_lores;
    wire         ov_hires, overlay_off, attr_map_on, shadow_we;
    wire  [18:0] mem_addr, ov_addr, at_addr;
    wire  [11:0] ov_stride, at_stride;
    wire  [7:0]  mem_rdata, ov_hscroll, ov_vscroll, font_base, ov_prio;
    wire  [7:0]  shadow_data;
    wire  [4:0]  at_hscroll, at_vscroll, at_cell_w, at_cell_h, shadow_addr;
    wire  [1:0]  pal_pf, pal_ov, ov_width;
    int          n_mismatch, samples_checked, nbytes;
    logic        newf = 1'b0;
    logic [18:0] first_addr;
    logic [7:0]  q[$];
    edls_sequencer u_edls_sequencer (
        .sys_clk, .reset_n, .list_enable, .list_base_address, .vsync_start,
        .line_start, .scan_line, .host_wr, .host_addr, .host_wdata, .mem_req,
        .mem_addr, .mem_ack, .mem_rdata, .line_valid, .ov_text, .ov_gfx,
        .ov_lores, .ov_hires, .overlay_off, .ov_addr, .ov_stride, .ov_hscroll,
        .ov_vscroll, .font_base, .attr_map_on, .at_addr, .at_stride,
        .at_hscroll, .at_vscroll, .at_cell_w, .at_cell_h, .pal_pf, .pal_ov,
        .ov_width, .ov_prio, .shadow_we, .shadow_addr, .shadow_data
    );
    edls_mem_model u_edls_mem_model (
        .sys_clk, .mem_req, .mem_addr, .mem_ack, .mem_rdata
    );
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Counts fetched bytes and notes the first address after each sync.
    always @(posedge sys_clk) begin
        if (vsync_start) newf <= 1'b1;
        else if (mem_ack) newf <= 1'b0;
        if (mem_ack && newf) first_addr <= mem_addr;
        if (mem_ack) nbytes <= nbytes + 1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task load(input logic [9:0] a);
        foreach (q[i]) u_edls_mem_model.mem[a + i] = q[i];
    endtask
    // Pulses vertical sync or a line start, then lets the line run out.
    task step(input logic vs, input logic [8:0] n);
        @(negedge sys_clk);
        vsync_start = vs;
        line_start = !vs;
        scan_line = n;
        @(negedge sys_clk);
        vsync_start = 1'b0;
        line_start = 1'b0;
        repeat (120) @(negedge sys_clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        n_mismatch++;
        $display("watchdog expired");
        final_report;
    end
    initial begin
        {reset_n, list_enable, vsync_start, line_start, host_wr} = 5'h00;
        {list_base_address, scan_line, host_addr, host_wdata} = 41'h0;
        q = '{8'he9, 8'h0f, 8'h02, 8'h45, 8'h23, 8'h05, 8'hbc, 8'h0a, 8'h11,
              8'h22, 8'h9a, 8'h01, 8'h02, 8'h07, 8'hff, 8'h03, 8'h03, 8'h04,
              8'h0f, 8'h1f, 8'hb2, 8'h5a};
        load(10'h100);
        q = '{8'h02, 8'h90};
        load(10'h116);
        q = '{8'h06, 8'ha8, 8'h03, 8'h00};
        load(10'h200);
        list_base_address = 19'h00100;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        step(1'b1, 9'h000);
        step(1'b0, 9'h008);
        chk({line_valid, nbytes[7:0]}, 9'h000);
        host_wr = 1'b1;
        host_addr = 5'h12;
        host_wdata = 8'h5c;
        @(negedge sys_clk);
        host_wr = 1'b0;
        chk({shadow_we, shadow_addr, shadow_data}, 14'h325c);
        $display("test 1 done");
        list_enable = 1'b1;
        repeat (4) @(negedge sys_clk);
        step(1'b1, 9'h000);
        step(1'b0, 9'h007);
        chk(nbytes, 0);
        step(1'b0, 9'h008);
        chk(nbytes, 22);
        chk(first_addr, 19'h00100);
        chk({line_valid, ov_text, ov_gfx, attr_map_on}, 4'hd);
        chk({ov_addr, ov_stride}, {19'h52345, 12'habc});
        chk({ov_hscroll, ov_vscroll}, 16'h1122);
        chk(font_base, 8'h9a);
        chk({at_addr, at_stride}, {19'h70201, 12'h3fc});
        chk({at_hscroll, at_vscroll, at_cell_w, at_cell_h}, 20'h191ff);
        chk({pal_pf, pal_ov, ov_width, ov_prio}, 14'h2e5a);
        step(1'b0, 9'h009);
        step(1'b0, 9'h00a);
        chk({line_valid, nbytes[7:0]}, 9'h116);
        step(1'b0, 9'h00b);
        chk(nbytes, 24);
        chk({line_valid, ov_text, ov_gfx, ov_addr}, {3'h5, 19'h52345});
        chk({ov_hires, attr_map_on}, 2'h3);
        step(1'b0, 9'h00c);
        step(1'b0, 9'h00d);
        chk({line_valid, nbytes[7:0]}, 9'h018);
        $display("test 2 done");
        u_edls_mem_model.lat = 2;
        list_base_address = 19'h00200;
        step(1'b1, 9'h000);
        chk({ov_hscroll, ov_vscroll, ov_width, ov_prio}, 26'h1ff);
        chk({attr_map_on, at_hscroll, at_vscroll}, 11'h000);
        chk({at_cell_w, at_cell_h, pal_pf, pal_ov}, 14'h0e71);
        chk(ov_addr, 19'h52345);
        chk(at_addr, 19'h70201);
        step(1'b0, 9'h008);
        chk(first_addr, 19'h00200);
        chk(nbytes, 28);
        chk({ov_gfx, ov_lores, ov_hires, ov_width, ov_prio}, 13'h1b00);
        chk(overlay_off, 1'b1);
        $display("test 3 done");
        final_report;
    end
endmodule // edls_sequencer_test
`default_nettype wire
